//--- rtl/wspmc_ctrl.sv
`timescale 1ns/10ps
`include "wspmc_cfg.svh"

// Notes on behaviour
// [R1] WAIT halts instruction processing at once.
// [R2] Peripherals run; memory and registers kept.
// [R3] Oscillator keeps running during wait.
// [R4] Enabled peripheral interrupt ends wait.
// [R5] Reset during wait: normal reset.
// [R6] Wait wake-up has no stabilisation delay.
// [R7] Stop only with watchdog disabled.
// [R8] Stop halts oscillator until interrupt or reset.
// [R9] Pin reset during stop: normal reset.
// [R10] Stop wake-up waits stabilisation delay.
// [R11] Wake-up keeps oscillator selection.
// [R12] From main: service, then next instruction.
// [R13] From NMI routine: resume, stay NMI.
// [R14] In IRQ, maskable wake: continue routine.
// [R15] In IRQ, NMI wake: run NMI first.
// [R16] Active watchdog turns STOP into WAIT.
// [R17] Global enable cleared: only reset wakes.
// [R18] No entry while enabled request pending.
// [R19] Global enable is option register bit 4.
// [R20] Option register clears on reset.
// [R21] Sample interrupts at instruction end.
// [R22] Stabilisation length is a parameter.
module wspmc_ctrl
  import wspmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_end_i,
  input wire logic wait_exec_i,
  input wire logic stop_exec_i,
  input wire logic [1:0] core_ctx_i,
  input wire logic opt_we_i,
  input wire logic [7:0] opt_wdata_i,
  input wire logic [3:0] irq_req_i,
  input wire logic nmi_req_i,
  input wire logic watchdog_active_i,
  input wire logic osc_tick_i,
  input wire logic osc_sel_i,
  output logic core_halt_o,
  output logic osc_run_o,
  output logic osc_sel_o,
  output logic periph_clk_en_o,
  output logic global_interrupt_enable_o,
  output logic irq_take_o,
  output logic nmi_take_o,
  output logic wake_o,
  output logic [1:0] resume_o,
  output logic [1:0] ctx_o,
  output logic [2:0] state_o
);
  wspmc_state_e state_reg;
  wspmc_state_e state_next;
  logic [1:0] ctx_reg;
  logic [1:0] resume_reg;
  logic [1:0] resume_next;
  logic osc_sel_reg;
  logic [7:0] opt_w;
  logic gie_w;
  logic irq_pend_w;
  logic any_pend_w;
  logic wake_req_w;
  logic enter_wait_w;
  logic enter_stop_w;
  logic stab_start_w;
  logic stab_done_w;
  logic wake_w;

  wspmc_optreg u_optreg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .opt_we_i(opt_we_i),
    .opt_wdata_i(opt_wdata_i),
    .opt_o(opt_w),
    .global_interrupt_enable_o(gie_w)
  );

  wspmc_stab u_stab (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(stab_start_w),
    .osc_tick_i(osc_tick_i),
    .done_o(stab_done_w)
  );

  // [R17] Maskable requests need the global enable.
  assign irq_pend_w = gie_w && (|irq_req_i);
  assign any_pend_w = irq_pend_w || nmi_req_i;
  // [R17] NMI wakes only when enabled globally.
  assign wake_req_w = gie_w && ((|irq_req_i) || nmi_req_i);

  // [R18] Entry refused while an NMI or an enabled maskable request is pending.
  assign enter_wait_w = (state_reg == WSPMC_RUN) && !any_pend_w &&
                        (wait_exec_i || (stop_exec_i && watchdog_active_i));
  // [R7] Stop requires watchdog off.
  assign enter_stop_w = (state_reg == WSPMC_RUN) && !any_pend_w && stop_exec_i &&
                        !watchdog_active_i;

  // [R10] Stabilisation begins on stop wake-up.
  assign stab_start_w = (state_reg == WSPMC_STOP) && wake_req_w;
  assign wake_w = (state_reg == WSPMC_WAKE);

  // Resume action chosen from context held at entry.
  always_comb begin
    resume_next = resume_reg;
    if ((state_reg == WSPMC_WAIT) || (state_reg == WSPMC_STOP)) begin
      if (ctx_reg == WSPMC_CTX_NMI) begin
        // [R13] Stay in NMI context.
        resume_next = WSPMC_RES_NEXT;
      end else if (ctx_reg == WSPMC_CTX_IRQ) begin
        // [R14] [R15] NMI first, else continue routine.
        resume_next = nmi_req_i ? WSPMC_RES_SERVICE_NMI : WSPMC_RES_NEXT;
      end else begin
        // [R12] Service waking interrupt first.
        resume_next = nmi_req_i ? WSPMC_RES_SERVICE_NMI : WSPMC_RES_SERVICE_IRQ;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      WSPMC_RUN: begin
        // [R1] [R16] Enter immediately.
        if (enter_stop_w) begin
          state_next = WSPMC_STOP;
        end else if (enter_wait_w) begin
          state_next = WSPMC_WAIT;
        end
      end
      WSPMC_WAIT: begin
        // [R4] [R6] Wake with no delay.
        if (wake_req_w) begin
          state_next = WSPMC_WAKE;
        end
      end
      WSPMC_STOP: begin
        // [R8] Held until an enabled request.
        if (wake_req_w) begin
          state_next = WSPMC_STAB;
        end
      end
      WSPMC_STAB: begin
        if (stab_done_w) begin
          state_next = WSPMC_WAKE;
        end
      end
      WSPMC_WAKE: begin
        state_next = WSPMC_RUN;
      end
      default: begin
        state_next = WSPMC_RUN;
      end
    endcase
  end

  // [R5] [R9] Reset restarts the normal procedure.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= WSPMC_RUN;
      ctx_reg <= WSPMC_CTX_NORMAL;
      resume_reg <= WSPMC_RES_NEXT;
      osc_sel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      resume_reg <= resume_next;
      if (enter_wait_w || enter_stop_w) begin
        ctx_reg <= core_ctx_i;
      end
      // [R11] Selection frozen across low-power states.
      if (state_reg == WSPMC_RUN) begin
        osc_sel_reg <= osc_sel_i;
      end
    end
  end

  // [R1] [R2] Core halted; peripherals keep state.
  assign core_halt_o = (state_reg != WSPMC_RUN) && (state_reg != WSPMC_WAKE);
  // [R3] [R8] Oscillator off only in stop.
  assign osc_run_o = (state_reg != WSPMC_STOP);
  assign periph_clk_en_o = (state_reg != WSPMC_STOP) && (state_reg != WSPMC_STAB);
  assign osc_sel_o = osc_sel_reg;
  assign global_interrupt_enable_o = gie_w;
  // [R21] Sampled at instruction end, NMI not masked.
  assign nmi_take_o = (state_reg == WSPMC_RUN) && instr_end_i && nmi_req_i;
  assign irq_take_o = (state_reg == WSPMC_RUN) && instr_end_i && !nmi_req_i && irq_pend_w &&
                      (core_ctx_i == WSPMC_CTX_NORMAL);
  assign wake_o = wake_w;
  assign resume_o = resume_reg;
  assign ctx_o = ctx_reg;
  assign state_o = state_reg;
endmodule

//--- shared/wspmc_cfg.svh
`ifndef WSPMC_CFG_SVH
`define WSPMC_CFG_SVH

// Interrupt option register layout and reset value.
`define WSPMC_OPT_ENABLE_BIT 4
`define WSPMC_OPT_RESET 8'h00
// Oscillator stabilisation delay after stop wake-up, in oscillator cycles.
`define WSPMC_STAB_CYCLES 16'h0100
`define WSPMC_STAB_W 16

`endif

//--- shared/wspmc_pkg.sv
package wspmc_pkg;
  typedef enum logic [2:0] {
    WSPMC_RUN = 3'b000,
    WSPMC_WAIT = 3'b001,
    WSPMC_STOP = 3'b011,
    WSPMC_STAB = 3'b010,
    WSPMC_WAKE = 3'b110
  } wspmc_state_e;

  typedef enum logic [1:0] {
    WSPMC_CTX_NORMAL = 2'b00,
    WSPMC_CTX_IRQ = 2'b01,
    WSPMC_CTX_NMI = 2'b10
  } wspmc_ctx_e;

  typedef enum logic [1:0] {
    WSPMC_RES_NEXT = 2'b00,
    WSPMC_RES_SERVICE_IRQ = 2'b01,
    WSPMC_RES_SERVICE_NMI = 2'b10
  } wspmc_resume_e;
endpackage

//--- rtl/wspmc_ior.sv
`timescale 1ns/10ps
`include "wspmc_cfg.svh"

module wspmc_optreg
  import wspmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic opt_we_i,
  input wire logic [7:0] opt_wdata_i,
  output logic [7:0] opt_o,
  output logic global_interrupt_enable_o
);
  logic [7:0] opt_reg;

  // [R20] Cleared on reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opt_reg <= `WSPMC_OPT_RESET;
    end else if (opt_we_i) begin
      opt_reg <= opt_wdata_i;
    end
  end

  assign opt_o = opt_reg;
  // [R19] Global enable bit.
  assign global_interrupt_enable_o = opt_reg[`WSPMC_OPT_ENABLE_BIT];
endmodule

//--- rtl/wspmc_stab.sv
`timescale 1ns/10ps
`include "wspmc_cfg.svh"

module wspmc_stab
  import wspmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic osc_tick_i,
  output logic done_o
);
  logic [`WSPMC_STAB_W-1:0] cnt_reg;
  logic [`WSPMC_STAB_W-1:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic last_w;

  // [R22] Counts restarted oscillator cycles.
  assign last_w = busy_reg && osc_tick_i && (cnt_reg == `WSPMC_STAB_CYCLES - 16'h0001);
  assign cnt_next = start_i ? 16'h0000 : (busy_reg && osc_tick_i) ? cnt_reg + 16'h0001 : cnt_reg;
  assign busy_next = start_i ? 1'b1 : (last_w ? 1'b0 : busy_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_o <= last_w;
    end
  end
endmodule

//--- tb/wspmc_monitor.sv
`timescale 1ns/10ps
module wspmc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_end_i,
  input wire logic wait_exec_i,
  input wire logic stop_exec_i,
  input wire logic opt_we_i,
  input wire logic [7:0] opt_wdata_i,
  input wire logic [3:0] irq_req_i,
  input wire logic nmi_req_i,
  input wire logic watchdog_active_i,
  input wire logic core_halt_o,
  input wire logic osc_run_o,
  input wire logic periph_clk_en_o,
  input wire logic global_interrupt_enable_o,
  input wire logic nmi_take_o,
  input wire logic [2:0] state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire run = state_o == 3'h0;
  wire gie = global_interrupt_enable_o;
  wire pend = nmi_req_i | (gie & (|irq_req_i));
  wire wreq = gie & ((|irq_req_i) | nmi_req_i);
  chk_wait_entry:
    assert property (run && wait_exec_i && !stop_exec_i && !pend |=> state_o == 3'h1)
      else $error("wait entry missed");
  chk_stop_entry:
    assert property (run && stop_exec_i && !pend |=>
      state_o == ($past(watchdog_active_i) ? 3'h1 : 3'h3)) else $error("stop entry wrong");
  chk_no_entry:
    assert property (run && pend |=> state_o == 3'h0) else $error("entry while pending");
  chk_wait_wake:
    assert property (state_o == 3'h1 && wreq |=> state_o == 3'h6 ##1 state_o == 3'h0)
      else $error("wait wake wrong");
  chk_stop_stab:
    assert property (state_o == 3'h3 && wreq |=> state_o == 3'h2) else $error("no stab");
  chk_gie_lock:
    assert property (!gie && (state_o == 3'h1 || state_o == 3'h3) |=> $stable(state_o))
      else $error("woke with enable low");
  chk_nmi_take:
    assert property (run && instr_end_i && nmi_req_i |-> nmi_take_o) else $error("nmi not taken");
  chk_gie_bit:
    assert property (opt_we_i |=> gie == $past(opt_wdata_i[4])) else $error("enable bit wrong");
  chk_stop_clocks:
    assert property (state_o == 3'h3 |-> !osc_run_o && !periph_clk_en_o && core_halt_o)
      else $error("stop clocks wrong");
endmodule

//--- tb/wspmc_core_model.sv
`timescale 1ns/10ps
module wspmc_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic core_halt_i,
  input wire logic osc_run_i,
  input wire logic slow_i,
  output logic instr_end_o = 1'b0,
  output logic osc_tick_o = 1'b0
);
  logic [1:0] cnt_reg = 2'h0;
  // An instruction ends every fourth cycle; a slow oscillator ticks every other cycle.
  always @(negedge clk_i) begin
    cnt_reg <= cnt_reg + 2'h1;
    instr_end_o <= !rst_i && !core_halt_i && cnt_reg == 2'h3;
    osc_tick_o <= osc_run_i && (!slow_i || cnt_reg[0]);
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_top;
  logic clk_i = 0, rst_i = 1, wait_exec_i = 0, stop_exec_i = 0, opt_we_i = 0, nmi_req_i = 0;
  logic watchdog_active_i = 0, osc_sel_i = 1, slow_i = 0, instr_end_i, osc_tick_i;
  logic [1:0] core_ctx_i = 2'h0, resume_o, ctx_o;
  logic [3:0] irq_req_i = 4'h0;
  logic [7:0] opt_wdata_i = 8'h00;
  logic [2:0] state_o;
  logic core_halt_o, osc_run_o, osc_sel_o, periph_clk_en_o, global_interrupt_enable_o;
  logic irq_take_o, nmi_take_o, wake_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #20 clk_i = ~clk_i;
  wspmc_ctrl u_dut (.clk_i, .rst_i, .instr_end_i, .wait_exec_i, .stop_exec_i, .core_ctx_i,
    .opt_we_i, .opt_wdata_i, .irq_req_i, .nmi_req_i, .watchdog_active_i, .osc_tick_i,
    .osc_sel_i, .core_halt_o, .osc_run_o, .osc_sel_o, .periph_clk_en_o,
    .global_interrupt_enable_o, .irq_take_o, .nmi_take_o, .wake_o, .resume_o, .ctx_o, .state_o);
  wspmc_core_model u_core (.clk_i, .rst_i, .core_halt_i(core_halt_o), .osc_run_i(osc_run_o),
    .slow_i, .instr_end_o(instr_end_i), .osc_tick_o(osc_tick_i));
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task set_gie(input logic [7:0] d, input logic e);
    opt_wdata_i = d;
    opt_we_i = 1;
    cyc(1);
    opt_we_i = 0;
    `CHK("gie", e, global_interrupt_enable_o)
  endtask
  task lp(input logic stp, wd, input logic [1:0] cx, input logic nm, input logic [1:0] res);
    int n;
    logic s;
    s = stp & !wd;
    core_ctx_i = cx;
    watchdog_active_i = wd;
    slow_i = (cx == 2'h2);
    stop_exec_i = stp;
    wait_exec_i = !stp;
    cyc(1);
    stop_exec_i = 0;
    wait_exec_i = 0;
    osc_sel_i = 0;
    `CHK("state", s ? 3'h3 : 3'h1, state_o)
    `CHK("halt", 1'b1, core_halt_o)
    `CHK("osc", !s, osc_run_o)
    `CHK("pclk", !s, periph_clk_en_o)
    cyc(3);
    if (nm) nmi_req_i = 1;
    else irq_req_i = 4'h8;
    n = 0;
    while (wake_o !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    if (n == 2000) begin
      n_mismatch++;
      conclude;
    end
    nmi_req_i = 0;
    irq_req_i = 4'h0;
    `CHK("resume", res, resume_o)
    `CHK("ctx", cx, ctx_o)
    `CHK("sel", 1'b1, osc_sel_o)
    `CHK("delay", 1'b1, s ? (n > 256) : (n == 1))
    osc_sel_i = 1;
    cyc(1);
    `CHK("run", 3'h0, state_o)
    cyc(4);
  endtask
  initial begin
    cyc(16);
    rst_i = 0;
    cyc(1);
    `CHK("rst gie", 1'b0, global_interrupt_enable_o)
    set_gie(8'hEF, 1'b0);
    set_gie(8'h10, 1'b1);
    lp(0, 0, 2'h0, 0, 2'h1);
    lp(0, 0, 2'h0, 1, 2'h2);
    lp(1, 1, 2'h1, 1, 2'h2);
    lp(1, 0, 2'h2, 0, 2'h0);
    lp(0, 0, 2'h1, 0, 2'h0);
    nmi_req_i = 1;
    wait_exec_i = 1;
    cyc(1);
    wait_exec_i = 0;
    `CHK("pending", 3'h0, state_o)
    cyc(5);
    nmi_req_i = 0;
    irq_req_i = 4'h2;
    core_ctx_i = 2'h0;
    repeat (8) begin
      cyc(1);
      #5 `CHK("irq take", instr_end_i, irq_take_o)
    end
    core_ctx_i = 2'h1;
    repeat (8) begin
      cyc(1);
      #5 `CHK("irq take ctx", 1'b0, irq_take_o)
    end
    irq_req_i = 4'h0;
    core_ctx_i = 2'h0;
    set_gie(8'h00, 1'b0);
    stop_exec_i = 1;
    cyc(1);
    stop_exec_i = 0;
    nmi_req_i = 1;
    cyc(6);
    `CHK("masked", 3'h3, state_o)
    rst_i = 1;
    cyc(2);
    rst_i = 0;
    nmi_req_i = 0;
    cyc(1);
    `CHK("reset", 3'h0, state_o)
    conclude;
  end
endmodule
bind wspmc_ctrl wspmc_monitor u_mon (.clk_i, .rst_i, .instr_end_i, .wait_exec_i, .stop_exec_i,
  .opt_we_i, .opt_wdata_i, .irq_req_i, .nmi_req_i, .watchdog_active_i, .core_halt_o,
  .osc_run_o, .periph_clk_en_o, .global_interrupt_enable_o, .nmi_take_o, .state_o);
